// File: verilog/mesc_pkg.sv
package mesc_pkg;
    // Register word offsets on the plain register port.
    localparam logic [3:0] MESC_OFF_SCALE = 4'h0;
    localparam logic [3:0] MESC_OFF_POWER = 4'h1;
    localparam logic [3:0] MESC_OFF_CONFIG = 4'h2;
    localparam logic [3:0] MESC_OFF_COMPARE = 4'h3;
    localparam logic [3:0] MESC_OFF_PHASE = 4'h4;
    localparam logic [3:0] MESC_OFF_PERIOD = 4'h5;
    localparam logic [3:0] MESC_OFF_STATUS = 4'h6;
    // Field positions.
    localparam int MESC_SCALE_W = 8;
    localparam int MESC_POFF_LSB = 6;
    localparam int MESC_POFF_W = 4;
    localparam int MESC_CFG_AUTO_BIT = 0;
    localparam int MESC_CFG_FPER_BIT = 1;
    localparam int MESC_FRAC_LSB = 8;
    // Reset values and limits.
    localparam logic [7:0] MESC_SCALE_RST = 8'h00;
    localparam logic [3:0] MESC_POFF_RST = 4'h0;
    localparam logic [3:0] MESC_POFF_ALL = 4'hf;
    localparam logic [7:0] MESC_SCALE_MAX = 8'hfe;
    localparam logic [15:0] MESC_MANUAL_OFFSET = 16'h0080;
    // Timing: 3 system-clock cycles of guard at period start, and at period end with fine period on.
    localparam logic [15:0] MESC_GUARD_CYC = 16'h0003;
    // Calibration needs at least 40 MHz; clock here is 125 MHz.
    localparam int MESC_MIN_CLK_MHZ = 40;
    localparam int MESC_CLK_MHZ = 125;
    typedef enum logic [1:0] {
        MESC_CAL_OFF = 2'b00,
        MESC_CAL_IDLE = 2'b01,
        MESC_CAL_RUN = 2'b10
    } mesc_cal_t;
endpackage

// File: verilog/mesc_scaler.sv
`timescale 1ns/100ps
// Turns a fine register value into a count of fine steps, auto or manual.
module mesc_scaler
    import mesc_pkg::*;
(
    input wire logic [15:0] fine_value,
    input wire logic [7:0] scale,
    input wire logic auto_on,
    output logic [7:0] steps
);
    // Auto: fraction (upper byte) times scale, top byte of the product.
    wire [15:0] product = {8'h00, fine_value[15:MESC_FRAC_LSB]} * {8'h00, scale};
    // Manual: value already scaled, top byte holds steps as written, no rounding offset added.
    wire [7:0] manual_steps = fine_value[15:MESC_FRAC_LSB];
    assign steps = auto_on ? product[15:8] : manual_steps;
endmodule

// File: verilog/mesc_guard.sv
`timescale 1ns/100ps
// Counts the coarse period and flags the windows where fine edges are blocked.
module mesc_guard
    import mesc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] period_coarse,
    input wire logic fine_period_on,
    output logic [15:0] count,
    output logic fine_allowed
);
    wire at_end = (count >= period_coarse);
    wire in_head = (count < MESC_GUARD_CYC);
    wire in_tail = fine_period_on && (count + MESC_GUARD_CYC > period_coarse);
    // Free-running coarse counter that wraps at the period value.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 16'h0000;
        end else if (at_end) begin
            count <= 16'h0000;
        end else begin
            count <= count + 16'h0001;
        end
    end
    assign fine_allowed = !in_head && !in_tail;
endmodule

// File: verilog/mesc_top.sv
`timescale 1ns/100ps
// Overview of operation
// - With auto-convert on, 8-bit scale converts fine values to edge delays.
// - All ones in calib_power_off stops and unpowers calibration logic.
// - Fine edges blocked first 3 cycles, and last 3 with fine period.
// - Auto-convert off: scale ignored for compare and phase (period stays scaled), software supplies pre-scaled fine values.
// - Calibration runs on the system clock, needing at least 40 MHz.
// - Calibration is independent of channels; one factor serves all.
// - Auto: fraction times scale gives fine steps moved at the edge.
// - Scale factor is an integer 0 to 254 fine steps per clock; only calibration results are held to it, software writes can load 255.
// - Fine period enable turns fine frequency control on or off.
module mesc_top
    import mesc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic protected_write_unlock,
    input wire logic [15:0] period_coarse,
    input wire logic cal_start,
    input wire logic [7:0] cal_result,
    output logic [7:0] compare_steps,
    output logic [7:0] phase_steps,
    output logic [7:0] period_steps,
    output logic fine_active,
    output logic cal_powered,
    output logic cal_busy
);
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] micro_step_scale;
    logic [3:0] calib_power_off;
    logic auto_convert_enable;
    logic fine_period_enable;
    logic [15:0] compare_fine;
    logic [15:0] phase_fine;
    logic [15:0] period_fine;
    logic cal_error;
    mesc_cal_t cal_state;
    mesc_cal_t next_cal_state;
    logic [7:0] cal_value;
    logic cal_done;

    // Write decode; protected fields need the unlock.
    wire wr_scale = reg_wr && reg_addr == MESC_OFF_SCALE && protected_write_unlock;
    wire wr_power = reg_wr && reg_addr == MESC_OFF_POWER && protected_write_unlock;
    wire wr_config = reg_wr && reg_addr == MESC_OFF_CONFIG;
    wire wr_compare = reg_wr && reg_addr == MESC_OFF_COMPARE;
    wire wr_phase = reg_wr && reg_addr == MESC_OFF_PHASE;
    wire wr_period = reg_wr && reg_addr == MESC_OFF_PERIOD;
    wire cal_off = (calib_power_off == MESC_POFF_ALL);
    // An out-of-range result is an error and cannot drive auto-convert.
    wire result_bad = cal_value > MESC_SCALE_MAX;
    wire auto_eff = auto_convert_enable && !cal_error;

    ////////////////////////////////////////////////////////////////////////////
    // Scale register: software or a finished calibration run updates it.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            micro_step_scale <= MESC_SCALE_RST;
        end else if (wr_scale) begin
            micro_step_scale <= reg_wdata[MESC_SCALE_W-1:0];
        end else if (cal_done && !result_bad) begin
            micro_step_scale <= cal_value;
        end
    end

    // Power field; reserved bits are not stored and read as zero.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            calib_power_off <= MESC_POFF_RST;
        end else if (wr_power) begin
            calib_power_off <= reg_wdata[MESC_POFF_LSB+MESC_POFF_W-1:MESC_POFF_LSB];
        end
    end

    // Configuration bits and fine values.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            auto_convert_enable <= 1'b0;
            fine_period_enable <= 1'b0;
            compare_fine <= 16'h0000;
            phase_fine <= 16'h0000;
            period_fine <= 16'h0000;
        end else begin
            if (wr_config) begin
                auto_convert_enable <= reg_wdata[MESC_CFG_AUTO_BIT];
                fine_period_enable <= reg_wdata[MESC_CFG_FPER_BIT];
            end
            if (wr_compare) begin
                compare_fine <= reg_wdata;
            end
            if (wr_phase) begin
                phase_fine <= reg_wdata;
            end
            if (wr_period) begin
                period_fine <= reg_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Calibration sequencer on the system clock, apart from every channel.
    // It takes one cycle to capture; the real diagnostics sit outside.
    always_comb begin
        next_cal_state = cal_state;
        case (cal_state)
            MESC_CAL_OFF: begin
                if (!cal_off) begin
                    next_cal_state = MESC_CAL_IDLE;
                end
            end
            MESC_CAL_IDLE: begin
                if (cal_off) begin
                    next_cal_state = MESC_CAL_OFF;
                end else if (cal_start) begin
                    next_cal_state = MESC_CAL_RUN;
                end
            end
            MESC_CAL_RUN: begin
                next_cal_state = cal_off ? MESC_CAL_OFF : MESC_CAL_IDLE;
            end
            default: begin
                next_cal_state = MESC_CAL_OFF;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cal_state <= MESC_CAL_OFF;
            cal_value <= MESC_SCALE_RST;
            cal_done <= 1'b0;
            cal_error <= 1'b0;
        end else begin
            cal_state <= next_cal_state;
            cal_done <= (cal_state == MESC_CAL_IDLE) && cal_start && !cal_off;
            if ((cal_state == MESC_CAL_IDLE) && cal_start && !cal_off) begin
                cal_value <= cal_result;
            end
            if (cal_done) begin
                cal_error <= result_bad;
            end else if (wr_scale) begin
                cal_error <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // One scale factor feeds all three converters.
    wire [7:0] cmp_raw;
    wire [7:0] phs_raw;
    wire [7:0] prd_raw;
    wire [15:0] tb_count;
    wire guard_ok;

    mesc_scaler u_cmp (
        .fine_value(compare_fine),
        .scale(micro_step_scale),
        .auto_on(auto_eff),
        .steps(cmp_raw)
    );

    mesc_scaler u_phs (
        .fine_value(phase_fine),
        .scale(micro_step_scale),
        .auto_on(auto_eff),
        .steps(phs_raw)
    );

    // Fine period only ever uses hardware scaling.
    mesc_scaler u_prd (
        .fine_value(period_fine),
        .scale(micro_step_scale),
        .auto_on(1'b1),
        .steps(prd_raw)
    );

    mesc_guard u_guard (
        .clk(clk),
        .rst_n(rst_n),
        .period_coarse(period_coarse),
        .fine_period_on(fine_period_enable),
        .count(tb_count),
        .fine_allowed(guard_ok)
    );

    // Registered outputs; steps forced to zero inside the guard windows.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            compare_steps <= 8'h00;
            phase_steps <= 8'h00;
            period_steps <= 8'h00;
            fine_active <= 1'b0;
            cal_powered <= 1'b0;
            cal_busy <= 1'b0;
        end else begin
            compare_steps <= guard_ok ? cmp_raw : 8'h00;
            phase_steps <= guard_ok ? phs_raw : 8'h00;
            period_steps <= (guard_ok && fine_period_enable) ? prd_raw : 8'h00;
            fine_active <= guard_ok;
            cal_powered <= !cal_off;
            cal_busy <= (next_cal_state == MESC_CAL_RUN);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped addresses read zero.
    wire [15:0] status_word = {12'h000, cal_busy, cal_error, cal_powered, guard_ok};
    wire [15:0] rd_mux =
        (reg_addr == MESC_OFF_SCALE) ? {8'h00, micro_step_scale} :
        (reg_addr == MESC_OFF_POWER) ? {6'h00, calib_power_off, 6'h00} :
        (reg_addr == MESC_OFF_CONFIG) ? {14'h0000, fine_period_enable, auto_convert_enable} :
        (reg_addr == MESC_OFF_COMPARE) ? compare_fine :
        (reg_addr == MESC_OFF_PHASE) ? phase_fine :
        (reg_addr == MESC_OFF_PERIOD) ? period_fine :
        (reg_addr == MESC_OFF_STATUS) ? status_word : 16'h0000;

    // Read data is valid only in the cycle after the strobe.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 16'h0000;
        end
    end
endmodule

// File: tb/mesc_top_props.sv
`timescale 1ns/100ps
// Port-side checks of the read-data, guard and calibration behaviour.
module mesc_top_props
    import mesc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic protected_write_unlock,
    input wire logic cal_start,
    input wire logic [7:0] compare_steps,
    input wire logic [7:0] period_steps,
    input wire logic fine_active,
    input wire logic cal_powered,
    input wire logic cal_busy
);
    logic [3:0] lo_cnt;
    wire pwr_wr = reg_wr && reg_addr == MESC_OFF_POWER && protected_write_unlock;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    // Length of the current blocked stretch, saturating so it never wraps back to 0.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) lo_cnt <= 4'h0;
        else if (fine_active) lo_cnt <= 4'h0;
        else if (lo_cnt != 4'hf) lo_cnt <= lo_cnt + 4'h1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // The capture may lag the request by one register stage, so two depths are allowed.
    property p_busy_cause; cal_busy |-> $past(cal_start, 1) || $past(cal_start, 2); endproperty
    property p_busy_pulse; cal_busy |=> !cal_busy; endproperty
    property p_busy_off; !cal_powered [*3] |-> !cal_busy; endproperty
    property p_rd_zero; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
    property p_guard_start; $fell(fine_active) |-> !fine_active [*3]; endproperty
    property p_guard_steps; !fine_active |-> compare_steps == 8'h00 && period_steps == 8'h00;
    endproperty
    property p_guard_max; lo_cnt < 4'h8; endproperty
    property p_pwr_fall; $fell(cal_powered) |-> $past(pwr_wr, 1) || $past(pwr_wr, 2); endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("busy without start");
    a_busy_pulse: assert property (p_busy_pulse) else $error("busy too long");
    a_busy_off: assert property (p_busy_off) else $error("busy while off");
    a_rd_zero: assert property (p_rd_zero) else $error("read data outside slot");
    a_guard_start: assert property (p_guard_start) else $error("guard too short");
    a_guard_steps: assert property (p_guard_steps) else $error("steps in guard");
    a_guard_max: assert property (p_guard_max) else $error("guard too long");
    a_pwr_fall: assert property (p_pwr_fall) else $error("power off unasked");
    c_busy: cover property (cal_busy);
    c_off: cover property ($fell(cal_powered));
    c_long_guard: cover property (!fine_active [*6]);
endmodule
bind mesc_top mesc_top_props i_props (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cal_start(cal_start),
    .protected_write_unlock(protected_write_unlock), .compare_steps(compare_steps),
    .period_steps(period_steps), .fine_active(fine_active), .cal_powered(cal_powered),
    .cal_busy(cal_busy));

// File: tb/mesc_top_test.sv
`timescale 1ns/100ps
// Bench that drives the register port and calibration inputs directly.
module mesc_top_test
    import mesc_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, unlock = 1'b0;
    logic cal_start = 1'b0, fine_active, cal_powered, cal_busy, seen;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, rv, period_coarse = 16'h0020;
    logic [7:0] cal_result = 8'h00, compare_steps, phase_steps, period_steps;
    int n_fail = 0, samples_checked = 0, lo;
    mesc_top i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .protected_write_unlock(unlock),
        .period_coarse(period_coarse), .cal_start(cal_start), .cal_result(cal_result),
        .compare_steps(compare_steps), .phase_steps(phase_steps), .period_steps(period_steps),
        .fine_active(fine_active), .cal_powered(cal_powered), .cal_busy(cal_busy));
    always #4 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    // Shared helpers; outputs are sampled 1 ns after the edge so updates have landed.
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    task act;
        for (int i = 0; i < 200; i++) begin
            @(posedge clk);
            #1;
            if (fine_active === 1'b1) break;
        end
    endtask
    task lowlen;
        act;
        for (int i = 0; i < 200 && fine_active !== 1'b0; i++) @(posedge clk) #1;
        for (lo = 0; lo < 50 && fine_active === 1'b0; lo++) @(posedge clk) #1;
    endtask
    // A result pulse; busy is watched over a short bounded span.
    task pulse(input logic [7:0] r);
        @(posedge clk);
        cal_result <= r;
        cal_start <= 1'b1;
        @(posedge clk);
        cal_start <= 1'b0;
        // Busy stands only in the cycle after the start edge, so look there first.
        #1 seen = (cal_busy === 1'b1);
        repeat (3) @(posedge clk) #1 seen = seen | (cal_busy === 1'b1);
    endtask
    task print_verdict;
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Reset values, the write lock and an unmapped read.
    task t_regs;
        rd(MESC_OFF_SCALE);
        chk("scale reset", 16'h0000, rv);
        wr(MESC_OFF_SCALE, 16'h0040);
        rd(MESC_OFF_SCALE);
        chk("locked scale", 16'h0000, rv);
        @(posedge clk) unlock <= 1'b1;
        wr(MESC_OFF_SCALE, 16'h0040);
        rd(MESC_OFF_SCALE);
        chk("scale", 16'h0040, rv);
        rd(4'hf);
        chk("unmapped", 16'h0000, rv);
    endtask
    // Auto scaling, the top scale value, then manual mode with period steps held at zero.
    task t_convert;
        wr(MESC_OFF_CONFIG, 16'h0001);
        wr(MESC_OFF_COMPARE, 16'h8000);
        act;
        chk("auto compare", 16'h0020, compare_steps);
        wr(MESC_OFF_SCALE, 16'h00fe);
        wr(MESC_OFF_COMPARE, 16'hff00);
        act;
        chk("max scale", 16'h00fd, compare_steps);
        wr(MESC_OFF_CONFIG, 16'h0000);
        wr(MESC_OFF_COMPARE, 16'h3700);
        wr(MESC_OFF_PHASE, 16'h4000);
        wr(MESC_OFF_PERIOD, 16'h8000);
        act;
        chk("manual compare", 16'h0037, compare_steps);
        chk("manual phase", 16'h0040, phase_steps);
        // Fine period is still off here, so its steps stay at zero.
        chk("period off", 16'h0000, period_steps);
    endtask
    // Blocked stretch is three cycles, longer once fine period control is on.
    task t_guard;
        lowlen;
        chk("start guard", 16'h0003, lo[15:0]);
        // Fine period does not depend on auto-convert; this write turns both on.
        wr(MESC_OFF_CONFIG, 16'h0003);
        lowlen;
        chk("end guard", 16'h0001, lo > 4);
        chk("period scaled", 16'h007f, period_steps);
        wr(MESC_OFF_CONFIG, 16'h0000);
        // Software clears the fine compare as it would near the guard windows.
        wr(MESC_OFF_COMPARE, 16'h0000);
        act;
        chk("cleared compare", 16'h0000, compare_steps);
    endtask
    // A good result is taken, an out-of-range one is refused and flagged.
    task t_cal;
        pulse(8'h77);
        chk("busy", 16'h0001, seen);
        rd(MESC_OFF_SCALE);
        chk("new scale", 16'h0077, rv);
        pulse(8'hff);
        rd(MESC_OFF_SCALE);
        chk("bad scale kept", 16'h0077, rv);
        rd(MESC_OFF_STATUS);
        chk("error flag", 16'h0001, rv[2]);
    endtask
    // All ones stops calibration; any other value brings it back.
    task t_power;
        wr(MESC_OFF_POWER, 16'h03c0);
        rd(MESC_OFF_POWER);
        chk("power field", 16'h03c0, rv);
        pulse(8'h22);
        chk("off busy", 16'h0000, seen);
        chk("powered off", 16'h0000, cal_powered);
        wr(MESC_OFF_POWER, 16'h0380);
        repeat (3) @(posedge clk);
        #1 chk("powered on", 16'h0001, cal_powered);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_convert;
        t_guard;
        t_cal;
        t_power;
        print_verdict;
    end
    // The whole sequence needs a few hundred cycles; this span is far beyond it.
    initial begin
        #200000;
        n_fail++;
        print_verdict;
    end
endmodule
